// [src/ram_tile.sv]
`timescale 1ns/1ps
`include "ram_tile_regs.svh"

module ram_tile
  import ram_tile_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     ce,
  input  wire logic [`APB_AW-1:0]       paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`APB_DW-1:0]       pwdata,
  output logic      [`APB_DW-1:0]       prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire side_req_s                side_a,
  input  wire side_req_s                side_b,
  output logic      [`WORD_W-1:0]       read_word_side_a,
  output logic      [`NARROW_W-1:0]     read_word_side_b
);
  tile_state_s                 st;
  tile_state_s                 next_st;
  side_req_s   [1:0]           req;
  logic        [1:0]           mem_en;
  logic        [1:0]           mem_we;
  logic        [1:0][`ROW_W-1:0]  mem_row;
  logic        [1:0][`WORD_W-1:0] mem_mask;
  logic        [1:0][`WORD_W-1:0] mem_wdata;
  logic        [1:0][`WORD_W-1:0] mem_rdata;
  logic        [1:0][`WORD_W-1:0] lane_word;
  width_e      [1:0]           wr_width;
  logic        [1:0][`LANE_W-1:0] wr_lane;

  assign req[0] = side_a;
  assign req[1] = side_b;

  // ------------------------------------------------------------
  // array and lane steering
  // ------------------------------------------------------------
  ram_tile_array u_array (
    .clk   (clk),
    .nrst  (nrst),
    .ce    (ce),
    .en    (mem_en),
    .we    (mem_we),
    .row   (mem_row),
    .mask  (mem_mask),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  for (genvar g = 0; g < 2; g++) begin : g_lane
    ram_tile_lanes u_lanes (
      .wr_width   (wr_width[g]),
      .wr_lane    (wr_lane[g]),
      .wr_word    (req[g].write_word),
      .rd_width   (st.pipe[g].width),
      .rd_lane    (st.pipe[g].lane),
      .rd_row     (mem_rdata[g]),
      .wr_mask    (mem_mask[g]),
      .wr_shifted (mem_wdata[g]),
      .rd_word    (lane_word[g])
    );
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic                  active;
    logic                  hit;
    logic                  clr;
    logic                  update;
    logic [`WORD_W-1:0]    value;
    width_e                w;
    active = 1'b0;
    hit    = 1'b0;
    clr    = 1'b0;
    update = 1'b0;
    value  = '0;
    w      = width_x1;
    next_st = st;

    // zero-wait slave: read data and error are prepared in the setup cycle
    next_st.apb.pready  = psel & ~penable;
    next_st.apb.pslverr = 1'b0;
    if (psel && !penable) begin
      unique case (paddr)
        `OFS_CFG:    next_st.apb.prdata = `APB_DW'({st.clear_timing_style, st.two_port});
        `OFS_SIDE_A: next_st.apb.prdata = `APB_DW'(st.side[0]);
        `OFS_SIDE_B: next_st.apb.prdata = `APB_DW'(st.side[1]);
        `OFS_STATUS: next_st.apb.prdata = `APB_DW'({st.two_port,
                                                    st.pipe[1].last_wrote, st.pipe[1].last_hit,
                                                    st.pipe[0].last_wrote, st.pipe[0].last_hit});
        default: begin
          next_st.apb.prdata  = '0;
          next_st.apb.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && st.apb.pready && pwrite) begin
      unique case (paddr)
        `OFS_CFG: begin
          next_st.two_port           = pwdata[`CFG_TWO_PORT_BIT];
          next_st.clear_timing_style = clear_style_e'(pwdata[`CFG_CLEAR_BIT]);
        end
        `OFS_SIDE_A: next_st.side[0] = side_cfg_s'(pwdata[`SIDE_CFG_W-1:0]);
        `OFS_SIDE_B: next_st.side[1] = side_cfg_s'(pwdata[`SIDE_CFG_W-1:0]);
        default: ;
      endcase
    end

    for (int i = 0; i < 2; i++) begin
      // side B only exists in two-port mode; side A narrows to 18 there
      active = (i == 0) || st.two_port;
      w      = eff_width(st.side[i].width_code, (i == 1) || st.two_port);
      hit    = req[i].gate && active
               && (req[i].bank_select == st.side[i].bank_match_value);
      clr    = req[i].register_clear
               && (st.clear_timing_style == clear_async || req[i].gate);
      wr_width[i]  = w;
      wr_lane[i]   = lane_of(w, req[i].location);
      mem_row[i]   = row_of(w, req[i].location);
      mem_en[i]    = hit && !clr;
      mem_we[i]    = req[i].store_strobe;

      // write data resolves against the captured width, so value sits in the low bits like the read word
      update = st.pipe[i].hit;
      value  = lane_word[i];
      if (st.pipe[i].wrote) begin
        unique case (st.side[i].collision_output_policy)
          new_data_forward: value  = st.pipe[i].wdata & low_mask(st.pipe[i].width);
          old_data_first:   value  = lane_word[i];
          default:          update = 1'b0;
        endcase
      end

      if (clr) begin
        // status flags are not pipeline registers and survive a clear
        next_st.pipe[i].hit   = 1'b0;
        next_st.pipe[i].wrote = 1'b0;
        next_st.pipe[i].width = width_x1;
        next_st.pipe[i].lane  = '0;
        next_st.pipe[i].wdata = '0;
        next_st.pipe[i].held  = '0;
        next_st.pipe[i].out   = '0;
      end else begin
        next_st.pipe[i].hit   = hit;
        next_st.pipe[i].wrote = hit && req[i].store_strobe;
        if (hit) begin
          next_st.pipe[i].width = w;
          next_st.pipe[i].lane  = wr_lane[i];
          next_st.pipe[i].wdata = req[i].write_word;
        end
        if (req[i].gate && active) begin
          next_st.pipe[i].last_hit   = hit;
          next_st.pipe[i].last_wrote = hit && req[i].store_strobe;
        end
        if (st.side[i].output_stage_choice == pipelined_output) begin
          if (update) begin
            next_st.pipe[i].held = value;
          end
          next_st.pipe[i].out = st.pipe[i].held;
        end else if (update) begin
          next_st.pipe[i].out = value;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= `TILE_STATE_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign prdata           = st.apb.prdata;
  assign pready           = st.apb.pready;
  assign pslverr          = st.apb.pslverr;
  assign read_word_side_a = st.pipe[0].out;
  assign read_word_side_b = st.pipe[1].out[`NARROW_W-1:0];
endmodule

// [src/ram_tile_regs.svh]
`ifndef RAM_TILE_REGS_SVH
`define RAM_TILE_REGS_SVH

// ------------------------------------------------------------
// array geometry
// ------------------------------------------------------------
`define ARRAY_BITS         9216
`define ARRAY_ROWS         256
`define ROW_W              8
`define WORD_W             36
`define NARROW_W           18
`define LOC_W              13
`define LANE_W             6
`define BANK_W             3
`define GROUP_BITS         6'h09

// ------------------------------------------------------------
// register map, field positions and reset values
// ------------------------------------------------------------
`define APB_AW             12
`define APB_DW             32
`define OFS_CFG            12'h000
`define OFS_SIDE_A         12'h004
`define OFS_SIDE_B         12'h008
`define OFS_STATUS         12'h00c
`define CFG_TWO_PORT_BIT   0
`define CFG_CLEAR_BIT      1
`define SIDE_CFG_W         9
`define STATUS_W           5
`define TILE_STATE_RESET   '0

`endif

// [src/ram_tile_pkg.sv]
package ram_tile_pkg;
  `include "ram_tile_regs.svh"

  typedef enum logic [2:0] {
    width_x1  = 3'b000,
    width_x2  = 3'b001,
    width_x4  = 3'b010,
    width_x9  = 3'b011,
    width_x18 = 3'b100,
    width_x36 = 3'b101
  } width_e;

  typedef enum logic [1:0] {
    policy_normal    = 2'b00,
    new_data_forward = 2'b01,
    old_data_first   = 2'b10
  } policy_e;

  typedef enum logic {
    unbuffered_output = 1'b0,
    pipelined_output  = 1'b1
  } stage_e;

  typedef enum logic {
    clear_async = 1'b0,
    clear_sync  = 1'b1
  } clear_style_e;

  typedef struct packed {
    logic                  gate;
    logic [`LOC_W-1:0]     location;
    logic [`WORD_W-1:0]    write_word;
    logic                  store_strobe;
    logic                  register_clear;
    logic [`BANK_W-1:0]    bank_select;
  } side_req_s;

  // layout matches the side configuration register bit for bit
  typedef struct packed {
    logic [1:0]            collision_output_policy;
    logic [`BANK_W-1:0]    bank_match_value;
    stage_e                output_stage_choice;
    logic [2:0]            width_code;
  } side_cfg_s;

  typedef struct packed {
    logic                  hit;
    logic                  wrote;
    logic                  last_hit;
    logic                  last_wrote;
    width_e                width;
    logic [`LANE_W-1:0]    lane;
    logic [`WORD_W-1:0]    wdata;
    logic [`WORD_W-1:0]    held;
    logic [`WORD_W-1:0]    out;
  } side_pipe_s;

  typedef struct packed {
    logic [`APB_DW-1:0]    prdata;
    logic                  pready;
    logic                  pslverr;
  } apb_s;

  typedef struct packed {
    logic                  two_port;
    clear_style_e          clear_timing_style;
    side_cfg_s [1:0]       side;
    side_pipe_s [1:0]      pipe;
    apb_s                  apb;
  } tile_state_s;

  function automatic logic [`LANE_W-1:0] width_bits(input width_e w);
    unique case (w)
      width_x1:  return 6'h01;
      width_x2:  return 6'h02;
      width_x4:  return 6'h04;
      width_x9:  return 6'h09;
      width_x18: return 6'h12;
      width_x36: return 6'h24;
    endcase
  endfunction

  function automatic logic [`WORD_W-1:0] low_mask(input width_e w);
    return (36'h1 << width_bits(w)) - 36'h1;
  endfunction

  // 36 is single-port only; the narrow side never exceeds 18
  function automatic width_e eff_width(input logic [2:0] code, input logic narrow);
    width_e w;
    w = width_x1;
    unique case (code)
      3'b000:  w = width_x1;
      3'b001:  w = width_x2;
      3'b010:  w = width_x4;
      3'b011:  w = width_x9;
      3'b100:  w = width_x18;
      3'b101:  w = narrow ? width_x18 : width_x36;
      default: w = width_x1;
    endcase
    return w;
  endfunction

  // narrow words sit in the low bits of each 9-bit group, four groups per row
  function automatic logic [`ROW_W-1:0] row_of(input width_e w, input logic [`LOC_W-1:0] loc);
    unique case (w)
      width_x1:  return loc[12:5];
      width_x2:  return loc[11:4];
      width_x4:  return loc[10:3];
      width_x9:  return loc[9:2];
      width_x18: return loc[8:1];
      width_x36: return loc[7:0];
    endcase
  endfunction

  function automatic logic [`LANE_W-1:0] lane_of(input width_e w, input logic [`LOC_W-1:0] loc);
    unique case (w)
      width_x1:  return `LANE_W'(6'(loc[4:3]) * `GROUP_BITS + 6'(loc[2:0]));
      width_x2:  return `LANE_W'(6'(loc[3:2]) * `GROUP_BITS + 6'({loc[1:0], 1'b0}));
      width_x4:  return `LANE_W'(6'(loc[2:1]) * `GROUP_BITS + 6'({loc[0], 2'b00}));
      width_x9:  return `LANE_W'(6'(loc[1:0]) * `GROUP_BITS);
      width_x18: return `LANE_W'(6'(loc[0]) * `GROUP_BITS * 6'h02);
      width_x36: return 6'h00;
    endcase
  endfunction
endpackage

// [src/ram_tile_array.sv]
`timescale 1ns/1ps
`include "ram_tile_regs.svh"

module ram_tile_array
  import ram_tile_pkg::*;
(
  input  wire logic                           clk,
  input  wire logic                           nrst,
  input  wire logic                           ce,
  input  wire logic [1:0]                     en,
  input  wire logic [1:0]                     we,
  input  wire logic [1:0][`ROW_W-1:0]         row,
  input  wire logic [1:0][`WORD_W-1:0]        mask,
  input  wire logic [1:0][`WORD_W-1:0]        wdata,
  output logic      [1:0][`WORD_W-1:0]        rdata
);
  // the cells are never reset: only the pipeline around them clears
  logic [`WORD_W-1:0] cells [`ARRAY_ROWS];

  // side 0 is written last, so it wins a bit both sides write at once
  always_ff @(posedge clk) begin
    if (ce) begin
      for (int i = 1; i >= 0; i--) begin
        for (int b = 0; b < `WORD_W; b++) begin
          if (en[i] && we[i] && mask[i][b]) begin
            cells[row[i]][b] <= wdata[i][b];
          end
        end
      end
    end
  end

  // read sees the cell before this edge's write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (en[i]) begin
          rdata[i] <= cells[row[i]];
        end
      end
    end
  end
endmodule

// [src/ram_tile_lanes.sv]
`timescale 1ns/1ps
`include "ram_tile_regs.svh"

module ram_tile_lanes
  import ram_tile_pkg::*;
(
  input  wire width_e                 wr_width,
  input  wire logic [`LANE_W-1:0]     wr_lane,
  input  wire logic [`WORD_W-1:0]     wr_word,
  input  wire width_e                 rd_width,
  input  wire logic [`LANE_W-1:0]     rd_lane,
  input  wire logic [`WORD_W-1:0]     rd_row,
  output logic      [`WORD_W-1:0]     wr_mask,
  output logic      [`WORD_W-1:0]     wr_shifted,
  output logic      [`WORD_W-1:0]     rd_word
);
  assign wr_mask    = low_mask(wr_width) << wr_lane;
  assign wr_shifted = (wr_word & low_mask(wr_width)) << wr_lane;
  assign rd_word    = (rd_row >> rd_lane) & low_mask(rd_width);
endmodule

// [verif/ram_fabric_user.sv]
`timescale 1ns/1ps
`include "ram_tile_regs.svh"

module ram_fabric_user
  import ram_tile_pkg::*;
(
  input  wire logic clk,
  output side_req_s req
);
  initial req = '0;
  // a released request zeroes gate, strobe and clear and flips its other fields so a stale value never looks valid
  task automatic release_req();
    req <= '{1'b0, ~req.location, ~req.write_word, 1'b0, 1'b0, ~req.bank_select};
  endtask
  // one gated cycle; the bank select acts as the top address bits
  task automatic access(input logic [12:0] l, input logic [35:0] w, input logic s,
                        input logic [2:0] b);
    @(posedge clk);
    // the fabric owns any decoding above the bank select and keeps each memory to one tile
    req <= '{1'b1, l, w, s, 1'b0, b};
    @(posedge clk);
    release_req();
  endtask
  // two idle cycles first let earlier traffic drain before the clear
  task automatic clr(input logic g);
    repeat (2) @(posedge clk);
    req <= '{g, req.location, req.write_word, 1'b0, 1'b1, req.bank_select};
    @(posedge clk);
    release_req();
  endtask
endmodule

// [verif/ram_tile_properties.sv]
`timescale 1ns/1ps
`include "ram_tile_regs.svh"

module ram_tile_properties
  import ram_tile_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 ce,
  input wire logic [`APB_AW-1:0]   paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [`APB_DW-1:0]   pwdata,
  input wire logic [`APB_DW-1:0]   prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire side_req_s            side_a,
  input wire side_req_s            side_b,
  input wire logic [`WORD_W-1:0]   read_word_side_a,
  input wire logic [`NARROW_W-1:0] read_word_side_b
);
  // ------------------------------------------------------------
  // configuration shadow, so each property knows the mode
  // ------------------------------------------------------------
  logic       two_port;
  logic       sync_clr;
  side_cfg_s  ca;
  logic [1:0] act_a;
  logic       apbw;
  logic       ok_a;
  logic       take_a;
  logic       fwd36;
  logic       quiet;

  assign apbw   = psel && penable && pready && pwrite;
  assign ok_a   = ce && !side_a.register_clear;
  assign take_a = ok_a && side_a.gate && side_a.bank_select == ca.bank_match_value;
  assign fwd36  = take_a && side_a.store_strobe && !two_port && ca.width_code == 3'h5
                  && ca.collision_output_policy == 2'h1;
  // a pipelined side may still carry an access from two edges back
  assign quiet  = !act_a[0] && (!act_a[1] || ca.output_stage_choice == unbuffered_output);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      two_port <= 1'b0;
      sync_clr <= 1'b0;
      ca       <= '0;
      act_a    <= '0;
    end else begin
      if (apbw && paddr == `OFS_CFG) begin
        two_port <= pwdata[`CFG_TWO_PORT_BIT];
        sync_clr <= pwdata[`CFG_CLEAR_BIT];
      end
      if (apbw && paddr == `OFS_SIDE_A) begin
        ca <= side_cfg_s'(pwdata[`SIDE_CFG_W-1:0]);
      end
      if (ce || apbw) begin
        act_a <= {act_a[0], take_a || side_a.register_clear || apbw};
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_clear_gated:
    assert property (side_a.register_clear && side_a.gate && ce |=> read_word_side_a == '0)
    else $error("side a clear left data");
  a_async_clear:
    assert property (!sync_clr && side_a.register_clear && ce |=> read_word_side_a == '0)
    else $error("ungated clear ignored");
  a_sync_clear:
    assert property (sync_clr && side_a.register_clear && !side_a.gate && ce && quiet
      && !apbw |=> $stable(read_word_side_a)) else $error("sync clear acted ungated");
  a_quiet_hold:
    assert property (ok_a && quiet && !apbw |=> $stable(read_word_side_a))
    else $error("side a output moved without access");
  a_freeze_ce:
    assert property (!ce |=> $stable(read_word_side_a) && $stable(read_word_side_b))
    else $error("output moved with enable low");
  a_fwd_unbuf:
    assert property (fwd36 && ca.output_stage_choice == unbuffered_output ##1 ok_a
      |=> read_word_side_a == $past(side_a.write_word, 2)) else $error("forward late");
  a_fwd_pipe:
    assert property (fwd36 && ca.output_stage_choice == pipelined_output ##1 ok_a ##1 ok_a
      |=> read_word_side_a == $past(side_a.write_word, 3)) else $error("pipelined late");
  a_normal_keeps:
    assert property (take_a && side_a.store_strobe && ca.collision_output_policy == 2'h0
      && ca.output_stage_choice == unbuffered_output ##1 (ok_a && !apbw)
      |=> $stable(read_word_side_a)) else $error("normal write moved output");
  a_b_single:
    assert property (!two_port && !$past(two_port) && !$past(two_port, 2)
      && !side_b.register_clear |=> $stable(read_word_side_b)) else $error("side b served");
  a_clear_b:
    assert property (two_port && side_b.register_clear && side_b.gate && ce
      |=> read_word_side_b == '0) else $error("side b clear left data");
endmodule

// [verif/ram_tile_tb.sv]
`timescale 1ns/1ps
`include "ram_tile_regs.svh"

module ram_tile_tb
  import ram_tile_pkg::*;
;
  localparam logic [35:0] V1 = 36'h123456789;
  localparam logic [35:0] V5 = 36'h9c3c3c3c3;
  logic                   clk = 1'b0;
  logic                   nrst = 1'b0;
  logic                   ce = 1'b1;
  logic [`APB_AW-1:0]     paddr = '0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [`APB_DW-1:0]     pwdata = '0;
  logic [`APB_DW-1:0]     prdata;
  logic                   pready;
  logic                   pslverr;
  side_req_s              side_a;
  side_req_s              side_b;
  logic [`WORD_W-1:0]     read_word_side_a;
  logic [`NARROW_W-1:0]   read_word_side_b;
  logic [`APB_DW-1:0]     q;
  logic                   err;
  int                     error_cnt = 0;
  int                     total_checks = 0;
  int                     wb[6] = '{1, 2, 4, 9, 18, 36};

  always #4 clk = ~clk;

  ram_tile u_dut (.clk, .nrst, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .side_a, .side_b, .read_word_side_a, .read_word_side_b);
  ram_fabric_user u_fa (.clk, .req(side_a));
  ram_fabric_user u_fb (.clk, .req(side_b));

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // pready and the answer are read at the edge itself, before that edge updates them
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      final_report();
    end
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic see_a(input int lat, input logic [35:0] e);
    repeat (lat) @(posedge clk);
    #1;
    chk("read a", e, read_word_side_a);
  endtask

  task automatic wpol(input logic [1:0] p, input logic [35:0] d, input logic [35:0] e);
    apb(1'b1, `OFS_SIDE_A, {p, 7'h05});
    u_fa.access(13'h3, d, 1'b1, 3'h0);
    see_a(1, e);
  endtask

  initial begin
    repeat (2500) @(posedge clk);
    error_cnt++;
    final_report();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a <= 16; a += 4) begin
      apb(1'b0, 12'(a), '0);
      chk("reg", '0, q);
      chk("slverr", 36'(a == 16), err);
    end
    u_fb.access(13'h9, 36'h3ffff, 1'b1, 3'h0);
    u_fb.access(13'h9, '0, 1'b0, 3'h0);
    repeat (2) @(posedge clk);
    #1;
    chk("read b", '0, 36'(read_word_side_b));
    // each single-port width, written then read back
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, `OFS_SIDE_A, c);
      u_fa.access(13'h0155, 36'h5a5c3a5a5, 1'b1, 3'h0);
      u_fa.access(13'h0155, '0, 1'b0, 3'h0);
      see_a(1, 36'h5a5c3a5a5 & ((36'h1 << wb[c]) - 36'h1));
    end
    wpol(2'h1, V1, V1);
    wpol(2'h2, 36'hfedcba987, V1);
    wpol(2'h0, 36'h0a5a5a5a5, V1);
    u_fa.access(13'h3, '0, 1'b0, 3'h0);
    see_a(1, 36'h0a5a5a5a5);
    // pipelined output adds one clock after an ungated clear
    apb(1'b1, `OFS_SIDE_A, 32'h08d);
    u_fa.clr(1'b0);
    see_a(0, '0);
    u_fa.access(13'h3, V5, 1'b1, 3'h0);
    see_a(1, '0);
    see_a(1, V5);
    apb(1'b1, `OFS_CFG, 32'h2);
    u_fa.clr(1'b0);
    see_a(1, V5);
    u_fa.clr(1'b1);
    see_a(0, '0);
    // bank match 5, then a stalled clock enable
    apb(1'b1, `OFS_SIDE_A, 32'h055);
    u_fa.access(13'h3, '0, 1'b0, 3'h4);
    see_a(1, '0);
    @(posedge clk);
    ce <= 1'b0;
    u_fa.access(13'h3, '0, 1'b0, 3'h5);
    ce <= 1'b1;
    see_a(1, '0);
    u_fa.access(13'h3, '0, 1'b0, 3'h5);
    see_a(1, V5);
    // two-port, both sides crossing locations in the same cycles
    apb(1'b1, `OFS_CFG, 32'h1);
    apb(1'b1, `OFS_SIDE_A, 32'h4);
    apb(1'b1, `OFS_SIDE_B, 32'h4);
    fork
      u_fa.access(13'h9, 36'h2b3c4, 1'b1, 3'h0);
      u_fb.access(13'h14, 36'h1d2e1, 1'b1, 3'h0);
    join
    fork
      u_fa.access(13'h14, '0, 1'b0, 3'h0);
      u_fb.access(13'h9, '0, 1'b0, 3'h0);
    join
    see_a(1, 36'h1d2e1);
    chk("read b", 36'h2b3c4, 36'(read_word_side_b));
    apb(1'b0, `OFS_STATUS, '0);
    chk("status", 36'h15, q);
    u_fb.clr(1'b1);
    see_a(0, 36'h1d2e1);
    chk("read b", '0, 36'(read_word_side_b));
    // code 5 narrows to 18 bits in two-port mode; policy code 3 behaves as normal
    apb(1'b1, `OFS_SIDE_A, 32'h185);
    u_fa.access(13'h9, 36'h7c0000155, 1'b1, 3'h0);
    see_a(1, 36'h1d2e1);
    u_fa.access(13'h9, '0, 1'b0, 3'h0);
    see_a(1, 36'h00155);
    final_report();
  end
endmodule

bind ram_tile ram_tile_properties u_props (.clk, .nrst, .ce, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .side_a, .side_b, .read_word_side_a,
  .read_word_side_b);
